// File: include/hbsap_regs.vh
/*
 Constants for the host bus and service acknowledge port: register indices,
 field positions, reset values and timing counts. Definitions only.
*/
`ifndef HBSAP_REGS_VH
`define HBSAP_REGS_VH

// ==========================================================================
// Register indices on the 7-bit address
`define HBSAP_ADDR_REVISION 7'h00
`define HBSAP_ADDR_RX_VECTOR 7'h01
`define HBSAP_ADDR_TX_VECTOR 7'h02
`define HBSAP_ADDR_MODEM_VECTOR 7'h03
`define HBSAP_ADDR_CHAN_MODE 7'h04
`define HBSAP_ADDR_MODEM_ENABLE 7'h05
`define HBSAP_ADDR_REQ_STATUS 7'h06
`define HBSAP_ADDR_MODEM_SIG1 7'h08
`define HBSAP_ADDR_MODEM_SIG2 7'h0c

// ==========================================================================
// Reset values and field positions
`define HBSAP_FW_REVISION 8'h11
`define HBSAP_RX_VECTOR_RST 8'h01
`define HBSAP_TX_VECTOR_RST 8'h02
`define HBSAP_MODEM_VECTOR_RST 8'h03
`define HBSAP_PARALLEL_BIT 0
`define HBSAP_MODEM_SIG_BIT 0

// ==========================================================================
// Timing
`define HBSAP_CLK_MHZ 125
`define HBSAP_RESET_MIN_CYCLES 10
`define HBSAP_INIT_CYCLES 5'd16
`define HBSAP_ACK_DELAY 2'd2

`endif

// File: design/hbsap_sync.v
/*
 Two flip-flop synchroniser for a group of pin inputs.
 Assumes the inputs are asynchronous to clk; reset value is a parameter.
*/
`timescale 1ns/1ps
module hbsap_sync #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b1}}
) (
    input wire clk,
    input wire srst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;

    always @(posedge clk) begin
        if (srst) begin
            meta_reg <= RST;
            q <= RST;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // hbsap_sync

// File: design/hbsap_clkdiv.v
/*
 Divide-by-two timing enable generator for on-chip timing.
 Assumes a single system clock; produces a tick on every other edge.
*/
`timescale 1ns/1ps
module hbsap_clkdiv (
    input wire clk,
    input wire srst,
    output reg tick
);
    always @(posedge clk) begin
        if (srst) begin
            tick <= 1'b0;
        end else begin
            tick <= ~tick;
        end
    end
endmodule // hbsap_clkdiv

// File: design/hbsap_port.v
/*
 Host register-access port with service request outputs and the service
 acknowledge daisy chain, plus channel 0 pin reuse and modem outputs.
 Assumes pins arrive asynchronously and are synchronised here; the open-drain
 and bidirectional pins are resolved outside from the enable outputs.
*/
`timescale 1ns/1ps
`include "hbsap_regs.vh"
module hbsap_port (
    input wire clk,
    input wire srst,
    input wire chip_select_n,
    input wire data_strobe_n,
    input wire read_write,
    input wire [6:0] address,
    input wire [7:0] host_data_in,
    output reg [7:0] host_data_out,
    output reg host_data_oe,
    output reg transfer_ack_oe,
    output reg rx_service_request_oe,
    output reg tx_service_request_oe,
    output reg modem_service_request_oe,
    input wire rx_service_ack_n,
    input wire tx_service_ack_n,
    input wire modem_service_ack_n,
    input wire chain_grant_in_n,
    output reg chain_pass_out_n,
    input wire [3:0] rx_need,
    input wire [3:0] tx_need,
    input wire [3:0] modem_lines,
    input wire tx_serial_0,
    input wire printer_strobe_n,
    input wire rx_pin_0,
    output reg rx_serial_0,
    output reg printer_ack_n,
    output reg tx_pin_0,
    output reg [3:0] request_to_send_n,
    output reg [3:0] terminal_ready_n,
    output reg channels_enable,
    output reg init_done
);
    // ======================================================================
    // Input synchronisers
    wire [15:0] sync_q;
    wire cs_s, ds_s, rw_s, ackr_s, ackt_s, ackm_s, grant_s, rxpin_s;
    wire [6:0] addr_s;
    wire [3:0] modem_s;

    hbsap_sync #(.W(16), .RST(16'hffff)) u_sync (
        .clk(clk),
        .srst(srst),
        .d({chip_select_n, data_strobe_n, read_write, rx_service_ack_n,
            tx_service_ack_n, modem_service_ack_n, chain_grant_in_n, rx_pin_0,
            address, modem_lines[0]}),
        .q(sync_q)
    );

    reg [3:0] modem_hi_meta_reg, modem_hi_reg;
    assign {cs_s, ds_s, rw_s, ackr_s, ackt_s, ackm_s, grant_s, rxpin_s} = sync_q[15:8];
    assign addr_s = sync_q[7:1];
    assign modem_s = {modem_hi_reg[3:1], sync_q[0]};

    // ======================================================================
    // Divided timing
    wire tick;

    hbsap_clkdiv u_div (
        .clk(clk),
        .srst(srst),
        .tick(tick)
    );

    // ======================================================================
    // Registers and state
    localparam ST_INIT = 2'd0;
    localparam ST_IDLE = 2'd1;
    localparam ST_WORK = 2'd2;
    localparam ST_ACK = 2'd3;

    reg [1:0] state_reg;
    reg [4:0] init_cnt_reg;
    reg [1:0] work_cnt_reg;
    reg [7:0] revision_reg, rx_vec_reg, tx_vec_reg, modem_vec_reg;
    reg [7:0] chan_mode_reg, modem_en_reg, modem_sig1_reg, modem_sig2_reg;
    reg [3:0] modem_prev_reg, modem_chg_reg;
    reg [2:0] ack_kind_reg;
    wire [7:0] host_data_s;
    reg [7:0] data_meta_reg, data_reg;

    // Register read decode, used by the read path
    function [7:0] reg_read;
        input [6:0] a;
        begin
            case (a)
                `HBSAP_ADDR_REVISION: reg_read = revision_reg;
                `HBSAP_ADDR_RX_VECTOR: reg_read = rx_vec_reg;
                `HBSAP_ADDR_TX_VECTOR: reg_read = tx_vec_reg;
                `HBSAP_ADDR_MODEM_VECTOR: reg_read = modem_vec_reg;
                `HBSAP_ADDR_CHAN_MODE: reg_read = chan_mode_reg;
                `HBSAP_ADDR_MODEM_ENABLE: reg_read = modem_en_reg;
                `HBSAP_ADDR_REQ_STATUS: reg_read = {4'h0, modem_chg_reg};
                `HBSAP_ADDR_MODEM_SIG1: reg_read = modem_sig1_reg;
                `HBSAP_ADDR_MODEM_SIG2: reg_read = modem_sig2_reg;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    assign host_data_s = data_reg;

    wire rx_pend = |rx_need;
    wire tx_pend = |tx_need;
    wire modem_pend = |modem_chg_reg;
    wire one_ack = (~ackr_s & ackt_s & ackm_s) | (ackr_s & ~ackt_s & ackm_s)
        | (ackr_s & ackt_s & ~ackm_s);
    wire host_start = ~cs_s & ~ds_s;
    wire svc_start = ~grant_s & ~ds_s & one_ack;
    wire svc_pend = (~ackr_s & rx_pend) | (~ackt_s & tx_pend) | (~ackm_s & modem_pend);
    wire cycle_live = ~ds_s & (ack_kind_reg != 3'b000 ? 1'b1 : ~cs_s);
    wire parallel0 = chan_mode_reg[`HBSAP_PARALLEL_BIT];
    wire [3:0] modem_new = modem_s ^ modem_prev_reg;

    // ======================================================================
    // Cycle sequencer
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_INIT;
            init_cnt_reg <= 5'd0;
            work_cnt_reg <= 2'd0;
            revision_reg <= 8'h00;
            rx_vec_reg <= 8'h00;
            tx_vec_reg <= 8'h00;
            modem_vec_reg <= 8'h00;
            chan_mode_reg <= 8'h00;
            modem_en_reg <= 8'h00;
            modem_sig1_reg <= 8'h00;
            modem_sig2_reg <= 8'h00;
            ack_kind_reg <= 3'b000;
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
            transfer_ack_oe <= 1'b0;
            chain_pass_out_n <= 1'b1;
            channels_enable <= 1'b0;
            init_done <= 1'b0;
            data_meta_reg <= 8'h00;
            data_reg <= 8'h00;
            modem_hi_meta_reg <= 4'hf;
            modem_hi_reg <= 4'hf;
        end else begin
            data_meta_reg <= host_data_in;
            data_reg <= data_meta_reg;
            modem_hi_meta_reg <= modem_lines;
            modem_hi_reg <= modem_hi_meta_reg;
            case (state_reg)
                ST_INIT: begin
                    if (tick) begin
                        init_cnt_reg <= init_cnt_reg + 5'd1;
                    end
                    rx_vec_reg <= `HBSAP_RX_VECTOR_RST;
                    tx_vec_reg <= `HBSAP_TX_VECTOR_RST;
                    modem_vec_reg <= `HBSAP_MODEM_VECTOR_RST;
                    channels_enable <= 1'b0;
                    if (init_cnt_reg == `HBSAP_INIT_CYCLES) begin
                        revision_reg <= `HBSAP_FW_REVISION;
                        init_done <= 1'b1;
                        channels_enable <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    chain_pass_out_n <= 1'b1;
                    if (svc_start) begin
                        if (svc_pend) begin
                            ack_kind_reg <= {~ackm_s, ~ackt_s, ~ackr_s};
                            work_cnt_reg <= 2'd0;
                            state_reg <= ST_WORK;
                        end else begin
                            chain_pass_out_n <= 1'b0;
                        end
                    end else if (host_start) begin
                        ack_kind_reg <= 3'b000;
                        work_cnt_reg <= 2'd0;
                        state_reg <= ST_WORK;
                    end
                end
                ST_WORK: begin
                    if (!cycle_live) begin
                        state_reg <= ST_IDLE;
                    end else if (work_cnt_reg == `HBSAP_ACK_DELAY) begin
                        state_reg <= ST_ACK;
                        transfer_ack_oe <= 1'b1;
                        if (ack_kind_reg[0]) begin
                            host_data_out <= rx_vec_reg;
                            host_data_oe <= 1'b1;
                        end else if (ack_kind_reg[1]) begin
                            host_data_out <= tx_vec_reg;
                            host_data_oe <= 1'b1;
                        end else if (ack_kind_reg[2]) begin
                            host_data_out <= modem_vec_reg;
                            host_data_oe <= 1'b1;
                        end else if (rw_s) begin
                            host_data_out <= reg_read(addr_s);
                            host_data_oe <= 1'b1;
                        end else begin
                            case (addr_s)
                                `HBSAP_ADDR_RX_VECTOR: rx_vec_reg <= host_data_s;
                                `HBSAP_ADDR_TX_VECTOR: tx_vec_reg <= host_data_s;
                                `HBSAP_ADDR_MODEM_VECTOR: modem_vec_reg <= host_data_s;
                                `HBSAP_ADDR_CHAN_MODE: chan_mode_reg <= host_data_s;
                                `HBSAP_ADDR_MODEM_ENABLE: modem_en_reg <= host_data_s;
                                `HBSAP_ADDR_MODEM_SIG1: modem_sig1_reg <= host_data_s;
                                `HBSAP_ADDR_MODEM_SIG2: modem_sig2_reg <= host_data_s;
                                default: ;
                            endcase
                        end
                    end else begin
                        work_cnt_reg <= work_cnt_reg + 2'd1;
                    end
                end
                ST_ACK: begin
                    if (!cycle_live) begin
                        transfer_ack_oe <= 1'b0;
                        host_data_oe <= 1'b0;
                        ack_kind_reg <= 3'b000;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_INIT;
            endcase
        end
    end

    // ======================================================================
    // Modem change tracking; a new change wins over the acknowledge clear
    always @(posedge clk) begin
        if (srst) begin
            modem_prev_reg <= 4'hf;
            modem_chg_reg <= 4'h0;
        end else begin
            modem_prev_reg <= modem_s;
            if (state_reg == ST_ACK && ack_kind_reg[2] && !cycle_live) begin
                modem_chg_reg <= modem_new & modem_en_reg[3:0];
            end else begin
                modem_chg_reg <= modem_chg_reg | (modem_new & modem_en_reg[3:0]);
            end
        end
    end

    // ======================================================================
    // Service requests, modem outputs and channel 0 pin reuse
    always @(posedge clk) begin
        if (srst) begin
            rx_service_request_oe <= 1'b0;
            tx_service_request_oe <= 1'b0;
            modem_service_request_oe <= 1'b0;
            request_to_send_n <= 4'hf;
            terminal_ready_n <= 4'hf;
            tx_pin_0 <= 1'b1;
            rx_serial_0 <= 1'b1;
            printer_ack_n <= 1'b1;
        end else begin
            rx_service_request_oe <= rx_pend & init_done;
            tx_service_request_oe <= tx_pend & init_done;
            modem_service_request_oe <= modem_pend & init_done;
            request_to_send_n <=
                {4{~modem_sig1_reg[`HBSAP_MODEM_SIG_BIT]}};
            terminal_ready_n <= {4{~modem_sig2_reg[`HBSAP_MODEM_SIG_BIT]}};
            tx_pin_0 <= parallel0 ? printer_strobe_n : tx_serial_0;
            rx_serial_0 <= parallel0 ? 1'b1 : rxpin_s;
            printer_ack_n <= parallel0 ? rxpin_s : 1'b1;
        end
    end
endmodule // hbsap_port

// File: tb/hbsap_chk.sv
/*
 Checker for the host port: cycle start, acknowledge timing, release,
 chain pass and request outputs. Bound to hbsap_port, sees its ports only.
*/
`timescale 1ns/1ps
module hbsap_chk (
    input wire clk,
    input wire srst,
    input wire chip_select_n,
    input wire data_strobe_n,
    input wire read_write,
    input wire chain_grant_in_n,
    input wire [3:0] rx_need,
    input wire [3:0] tx_need,
    input wire transfer_ack_oe,
    input wire host_data_oe,
    input wire chain_pass_out_n,
    input wire rx_service_request_oe,
    input wire tx_service_request_oe,
    input wire init_done,
    input wire channels_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_rst;
        disable iff (1'b0) srst |=> !transfer_ack_oe && !host_data_oe && chain_pass_out_n;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    property p_src;
        $rose(transfer_ack_oe) |-> !$past(data_strobe_n, 3) &&
            (!$past(chip_select_n, 3) || !$past(chain_grant_in_n, 3));
    endproperty
    a_src: assert property (p_src) else $error("ack without a started cycle");
    property p_ack;
        $fell(data_strobe_n) && !chip_select_n && init_done |-> ##[3:7] transfer_ack_oe;
    endproperty
    a_ack: assert property (p_ack) else $error("host cycle not acknowledged");
    property p_rel;
        $rose(data_strobe_n) |-> ##[1:7] (!transfer_ack_oe && !host_data_oe);
    endproperty
    a_rel: assert property (p_rel) else $error("ack or data not released");
    property p_dir;
        $rose(transfer_ack_oe) |-> host_data_oe == $past(read_write, 3);
    endproperty
    a_dir: assert property (p_dir) else $error("data drive against direction");
    property p_req;
        (init_done && $stable(rx_need) && $stable(tx_need))[*4] |->
            rx_service_request_oe == (|rx_need) && tx_service_request_oe == (|tx_need);
    endproperty
    a_req: assert property (p_req) else $error("request out of step");
    property p_own;
        transfer_ack_oe && chip_select_n |-> chain_pass_out_n;
    endproperty
    a_own: assert property (p_own) else $error("pass while answering");
    property p_init;
        !init_done |-> !channels_enable;
    endproperty
    a_init: assert property (p_init) else $error("channels on before init");
endmodule // hbsap_chk

// File: tb/hbsap_host.sv
/*
 Host bus model: register and service acknowledge cycles on the pins.
 Assumes ack and dev_oe come straight from the device's enables.
*/
`timescale 1ns/1ps
module hbsap_host (
    input wire clk,
    input wire ack,
    input wire dev_oe,
    output logic cs_n = 1'b1,
    output logic ds_n = 1'b1,
    output logic rw = 1'b1,
    output logic [6:0] addr = 7'h00,
    output logic [7:0] dout = 8'h00,
    output logic doe = 1'b0,
    output logic [2:0] sack_n = 3'h7,
    output logic grant_n = 1'b1
);
    logic gdis = 1'b0;
    // ==========================================================
    // One cycle; k 0 host access, 1..3 rx/tx/modem acknowledge
    task automatic xfer(input int k, input logic w, input logic [6:0] a,
                        input logic [7:0] d, output logic ok);
        int n;
        @(negedge clk);
        rw = ~w;
        addr = a;
        dout = d;
        doe = w;
        if (k == 0) begin
            cs_n = 1'b0;
        end else begin
            grant_n = gdis;
            sack_n[k-1] = 1'b0;
        end
        ds_n = 1'b0;
        n = 0;
        while (!ack && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        ok = ack;
        @(negedge clk);
        cs_n = 1'b1;
        ds_n = 1'b1;
        grant_n = 1'b1;
        sack_n = 3'h7;
        doe = 1'b0;
        n = 0;
        while ((ack || dev_oe) && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) ok = 1'b0;
    endtask
endmodule // hbsap_host

// File: tb/tb.sv
/*
 Testbench for hbsap_port: host model drives the pins, a monitor checks
 read data against a queue. Assumes the host model and checker files.
*/
`timescale 1ns/1ps
`include "hbsap_regs.vh"
module tb;
    logic clk = 1'b0, srst = 1'b1, ok, ack_q = 1'b0, pass_lo = 1'b0;
    logic [3:0] rx_need = 4'h0, tx_need = 4'h0, modem_lines = 4'h0;
    logic tx_serial_0 = 1'b0, printer_strobe_n = 1'b1, rx_pin_0 = 1'b1;
    logic [7:0] last = 8'h00, v [1:3];
    logic [7:0] q [$];
    int n_mismatch = 0, total_checks = 0, cyc = 0, i, m;
    wire cs_n, ds_n, rw, doe, grant_n, transfer_ack_oe, host_data_oe, chain_pass_out_n;
    wire rx_oe, tx_oe, md_oe, rx_serial_0, printer_ack_n, tx_pin_0, init_done, chans_on;
    wire [2:0] sack_n;
    wire [6:0] addr;
    wire [7:0] dout, host_data_out;
    wire [3:0] rts_n, dtr_n;
    // Undriven bus floats: show a value that keeps changing
    wire [7:0] bus = doe ? dout : (host_data_oe ? host_data_out : ~last);
    initial forever #4 clk = ~clk;
    always @(posedge clk) last <= bus;
    hbsap_host h (.clk(clk), .ack(transfer_ack_oe), .dev_oe(host_data_oe), .cs_n(cs_n),
        .ds_n(ds_n), .rw(rw), .addr(addr), .dout(dout), .doe(doe), .sack_n(sack_n),
        .grant_n(grant_n));
    hbsap_port DUT (.clk(clk), .srst(srst), .chip_select_n(cs_n), .data_strobe_n(ds_n),
        .read_write(rw), .address(addr), .host_data_in(bus), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .transfer_ack_oe(transfer_ack_oe),
        .rx_service_request_oe(rx_oe), .tx_service_request_oe(tx_oe),
        .modem_service_request_oe(md_oe), .rx_service_ack_n(sack_n[0]),
        .tx_service_ack_n(sack_n[1]), .modem_service_ack_n(sack_n[2]),
        .chain_grant_in_n(grant_n), .chain_pass_out_n(chain_pass_out_n), .rx_need(rx_need),
        .tx_need(tx_need), .modem_lines(modem_lines), .tx_serial_0(tx_serial_0),
        .printer_strobe_n(printer_strobe_n), .rx_pin_0(rx_pin_0), .rx_serial_0(rx_serial_0),
        .printer_ack_n(printer_ack_n), .tx_pin_0(tx_pin_0), .request_to_send_n(rts_n),
        .terminal_ready_n(dtr_n), .channels_enable(chans_on), .init_done(init_done));
    task chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task do_reset(input int c);
        int n;
        srst = 1'b1;
        repeat (c) @(negedge clk);
        chk(chain_pass_out_n, 1'b1);
        srst = 1'b0;
        n = 0;
        while (!init_done && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(chans_on, 1'b1);
        q.push_back(`HBSAP_FW_REVISION);
        h.xfer(0, 1'b0, 7'h00, 8'h00, ok);
        $display("reset test done");
    endtask
    // ==========================================================
    // Monitor: compare each read answer with the oldest note
    always @(negedge clk) begin
        ack_q <= transfer_ack_oe;
        if (!chain_pass_out_n) pass_lo = 1'b1;
        if (transfer_ack_oe && !ack_q && host_data_oe) begin
            if (q.size() == 0) chk(8'hxx, host_data_out);
            else chk(host_data_out, q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        i = $urandom(32'h36ae4f5f);
        do_reset(20);
        for (i = 1; i < 4; i++) begin
            v[i] = $urandom;
            h.xfer(0, 1'b1, 7'(i), v[i], ok);
            q.push_back(v[i]);
            h.xfer(0, 1'b0, 7'(i), 8'h00, ok);
        end
        $display("register test done");
        rx_need = 4'($urandom_range(15, 1));
        tx_need = 4'($urandom_range(15, 1));
        h.xfer(0, 1'b1, 7'h05, 8'h0f, ok);
        modem_lines = ~modem_lines;
        for (i = 0; i < 30 && !md_oe; i++) @(negedge clk);
        chk({rx_oe, tx_oe, md_oe}, 3'h7);
        q.push_back(8'h0f);
        h.xfer(0, 1'b0, 7'h06, 8'h00, ok);
        for (i = 1; i < 4; i++) begin
            q.push_back(v[i]);
            pass_lo = 1'b0;
            h.xfer(i, 1'b0, 7'h00, 8'h00, ok);
            chk({ok, pass_lo}, 2'h2);
        end
        repeat (3) @(negedge clk);
        chk(md_oe, 1'b0);
        rx_need = 4'h0;
        repeat (4) @(negedge clk);
        chk(rx_oe, 1'b0);
        pass_lo = 1'b0;
        h.xfer(1, 1'b0, 7'h00, 8'h00, ok);
        chk({ok, pass_lo}, 2'h1);
        h.gdis = 1'b1;
        h.xfer(2, 1'b0, 7'h00, 8'h00, ok);
        chk(ok, 1'b0);
        h.gdis = 1'b0;
        $display("service test done");
        for (m = 0; m < 2; m++) begin
            h.xfer(0, 1'b1, 7'h08, 8'(m), ok);
            h.xfer(0, 1'b1, 7'h0c, 8'(1 - m), ok);
            chk(rts_n, {4{~m[0]}});
            chk(dtr_n, {4{m[0]}});
            h.xfer(0, 1'b1, 7'h04, 8'(m), ok);
            for (i = 0; i < 4; i++) begin
                tx_serial_0 = 1'($urandom);
                printer_strobe_n = 1'($urandom);
                rx_pin_0 = 1'($urandom);
                repeat (5) @(negedge clk);
                chk(tx_pin_0, m ? printer_strobe_n : tx_serial_0);
                chk(m ? printer_ack_n : rx_serial_0, rx_pin_0);
            end
        end
        $display("pin test done");
        do_reset(10);
        print_verdict();
    end
endmodule // tb
bind hbsap_port hbsap_chk u_chk (.clk(clk), .srst(srst), .chip_select_n(chip_select_n),
    .data_strobe_n(data_strobe_n), .read_write(read_write), .chain_grant_in_n(chain_grant_in_n),
    .rx_need(rx_need), .tx_need(tx_need), .transfer_ack_oe(transfer_ack_oe),
    .host_data_oe(host_data_oe), .chain_pass_out_n(chain_pass_out_n),
    .rx_service_request_oe(rx_service_request_oe), .tx_service_request_oe(tx_service_request_oe),
    .init_done(init_done), .channels_enable(channels_enable));
